// File: design/fp_operate_dispatch.v
// Floating-point operate unit: alignment checks, operand gathering, routine dispatch and write-back
`timescale 1ns/1ps
`default_nettype none
`include "fp_operate_map.vh"
module fp_operate_dispatch (
  // Clock and reset
  input wire ref_clk,
  input wire sys_rst,
  // Avalon-MM slave
  input wire [8:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // Events
  output reg irq,
  output reg trap_request,
  output reg float_exception_flag
);
  localparam ST_IDLE = 3'd0;
  localparam ST_CHECK = 3'd1;
  localparam ST_ISSUE = 3'd2;
  localparam ST_CAPT = 3'd3;
  localparam ST_EXEC = 3'd4;
  localparam ST_WRITE = 3'd5;
  localparam ST_DONE = 3'd6;

  reg [2:0] state;
  reg [23:0] instr;
  reg [4:0] cexc;
  reg [1:0] fcc;
  reg [2:0] ftt;
  reg [1:0] irq_status;
  reg [1:0] irq_enable;
  reg mem_pend;
  reg [3:0] fcnt;
  reg [2:0] wcnt;
  reg [127:0] opa;
  reg [127:0] opb;
  reg [127:0] res;

  // Per-opcode shape: {known, src1 prec, src2 prec, dest prec}
  function [6:0] op_shape;
    input [8:0] op;
    begin
      case (op)
        `OP_INT_TO_SINGLE: op_shape = {1'b1, `P_NONE, `P_S, `P_S};
        `OP_INT_TO_DOUBLE: op_shape = {1'b1, `P_NONE, `P_S, `P_D};
        `OP_INT_TO_QUAD: op_shape = {1'b1, `P_NONE, `P_S, `P_Q};
        `OP_SINGLE_TO_INT: op_shape = {1'b1, `P_NONE, `P_S, `P_S};
        `OP_DOUBLE_TO_INT: op_shape = {1'b1, `P_NONE, `P_D, `P_S};
        `OP_QUAD_TO_INT: op_shape = {1'b1, `P_NONE, `P_Q, `P_S};
        `OP_SINGLE_TO_DBL: op_shape = {1'b1, `P_NONE, `P_S, `P_D};
        `OP_SINGLE_TO_QUAD: op_shape = {1'b1, `P_NONE, `P_S, `P_Q};
        `OP_DOUBLE_TO_SGL: op_shape = {1'b1, `P_NONE, `P_D, `P_S};
        `OP_DOUBLE_TO_QUAD: op_shape = {1'b1, `P_NONE, `P_D, `P_Q};
        `OP_QUAD_TO_SGL: op_shape = {1'b1, `P_NONE, `P_Q, `P_S};
        `OP_QUAD_TO_DBL: op_shape = {1'b1, `P_NONE, `P_Q, `P_D};
        `OP_MOVE_SINGLE: op_shape = {1'b1, `P_NONE, `P_S, `P_S};
        `OP_NEGATE_SINGLE: op_shape = {1'b1, `P_NONE, `P_S, `P_S};
        `OP_ABS_SINGLE: op_shape = {1'b1, `P_NONE, `P_S, `P_S};
        `OP_SQRT_SINGLE: op_shape = {1'b1, `P_NONE, `P_S, `P_S};
        `OP_SQRT_DOUBLE: op_shape = {1'b1, `P_NONE, `P_D, `P_D};
        `OP_SQRT_QUAD: op_shape = {1'b1, `P_NONE, `P_Q, `P_Q};
        `OP_MUL_SINGLE: op_shape = {1'b1, `P_S, `P_S, `P_S};
        `OP_DIV_SINGLE: op_shape = {1'b1, `P_S, `P_S, `P_S};
        `OP_MUL_DOUBLE: op_shape = {1'b1, `P_D, `P_D, `P_D};
        `OP_SMUL_TO_DOUBLE: op_shape = {1'b1, `P_S, `P_S, `P_D};
        `OP_DIV_DOUBLE: op_shape = {1'b1, `P_D, `P_D, `P_D};
        `OP_MUL_QUAD: op_shape = {1'b1, `P_Q, `P_Q, `P_Q};
        `OP_DMUL_TO_QUAD: op_shape = {1'b1, `P_D, `P_D, `P_Q};
        `OP_DIV_QUAD: op_shape = {1'b1, `P_Q, `P_Q, `P_Q};
        `OP_CMP_SINGLE: op_shape = {1'b1, `P_S, `P_S, `P_NONE};
        default: op_shape = {1'b0, `P_NONE, `P_NONE, `P_NONE};
      endcase
    end
  endfunction

  function [2:0] words;
    input [1:0] p;
    begin
      words = (p == `P_Q) ? 3'd4 : {1'b0, p};
    end
  endfunction

  function [31:0] lane_merge;
    input [31:0] old;
    input [31:0] neu;
    input [3:0] be;
    integer k;
    begin
      lane_merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (be[k]) begin
          lane_merge[k*8 +: 8] = neu[k*8 +: 8];
        end
      end
    end
  endfunction

  // Decode of the held instruction
  wire [8:0] opf = instr[`INS_OPF_LSB +: 9];
  wire [6:0] shape = op_shape(opf);
  wire [2:0] n1 = words(shape[5:4]);
  wire [2:0] n2 = words(shape[3:2]);
  wire [2:0] nd = words(shape[1:0]);
  // Quad by quad gathers eight words, one bit more than a single operand count
  wire [3:0] nsrc = {1'b0, n1} + {1'b0, n2};
  wire [4:0] base1;
  wire [4:0] base2;
  wire [4:0] based;
  wire mis1;
  wire mis2;
  wire misd;

  reg_spec_align u_align_rs1 (
    .spec(instr[`INS_RS1_LSB +: 5]),
    .prec(shape[5:4]),
    .base(base1),
    .misaligned(mis1)
  );
  reg_spec_align u_align_rs2 (
    .spec(instr[`INS_RS2_LSB +: 5]),
    .prec(shape[3:2]),
    .base(base2),
    .misaligned(mis2)
  );
  reg_spec_align u_align_rd (
    .spec(instr[`INS_RD_LSB +: 5]),
    .prec(shape[1:0]),
    .base(based),
    .misaligned(misd)
  );

  // Bus request classification
  wire bus_req = (avs_read | avs_write) & avs_waitrequest & ~mem_pend;
  wire fp_hit = avs_address[`FPREG_WIN_BIT];
  wire [8:0] word_addr = {avs_address[8:2], 2'b00};
  // Register-file access and new instructions wait while an operate runs
  wire bus_fp_ok = bus_req & fp_hit & (state == ST_IDLE);
  wire launch = bus_req & avs_write & ~fp_hit & (word_addr == `OFS_INSTR) & (state == ST_IDLE);
  wire clr_wr = bus_req & avs_write & ~fp_hit & (word_addr == `OFS_IRQ_CLEAR);
  wire ctl_ok = bus_req & ~fp_hit & ~((word_addr == `OFS_INSTR) & avs_write & (state != ST_IDLE));
  wire [31:0] instr_merged = lane_merge({8'h00, instr}, avs_writedata, avs_byteenable);

  // Register file port sharing
  wire [3:0] fidx = (fcnt < {1'b0, n1}) ? fcnt : fcnt - {1'b0, n1};
  wire [4:0] fetch_addr = ((fcnt < {1'b0, n1}) ? base1 : base2) | {3'b000, fidx[1:0]};
  wire mem_we = (bus_fp_ok & avs_write) | (state == ST_WRITE);
  wire [4:0] mem_waddr = (state == ST_WRITE) ? (based | {3'b000, wcnt[1:0]}) : avs_address[6:2];
  wire [31:0] mem_wdata = (state == ST_WRITE) ? res[127:96] : avs_writedata;
  wire [3:0] mem_wbe = (state == ST_WRITE) ? 4'hf : avs_byteenable;
  wire [4:0] mem_raddr = (state == ST_ISSUE) ? fetch_addr : avs_address[6:2];
  wire [31:0] mem_q;

  fp_reg_file #(
    .WIDTH(32),
    .DEPTH(32),
    .AW(5)
  ) u_regs (
    .ref_clk(ref_clk),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .wbe(mem_wbe),
    .raddr(mem_raddr),
    .rdata(mem_q)
  );

  // Routines: result, exception vector, condition vector, completion
  reg [127:0] r_val;
  reg [4:0] r_exc;
  reg [1:0] r_fcc;
  reg r_fcc_valid;
  reg r_done;
  reg [31:0] ka;
  reg [31:0] kb;
  reg nan_a;
  reg nan_b;

  always @* begin
    r_val = 128'h0;
    r_exc = 5'h00;
    r_fcc = 2'h0;
    r_fcc_valid = 1'b0;
    r_done = 1'b0;
    nan_a = (&opa[30:23]) & (|opa[22:0]);
    nan_b = (&opb[30:23]) & (|opb[22:0]);
    ka = opa[31] ? ~opa[31:0] : (opa[31:0] ^ 32'h80000000);
    kb = opb[31] ? ~opb[31:0] : (opb[31:0] ^ 32'h80000000);
    case (opf)
      `OP_MOVE_SINGLE: begin
        r_val = {96'h0, opb[31:0]};
        r_done = 1'b1;
      end
      `OP_NEGATE_SINGLE: begin
        r_val = {96'h0, opb[31:0] ^ 32'h80000000};
        r_done = 1'b1;
      end
      `OP_ABS_SINGLE: begin
        r_val = {96'h0, opb[31:0] & 32'h7fffffff};
        r_done = 1'b1;
      end
      `OP_CMP_SINGLE: begin
        r_done = 1'b1;
        r_fcc_valid = 1'b1;
        // Signalling NaN operand raises invalid in the top exception bit
        r_exc = {(nan_a & ~opa[22]) | (nan_b & ~opb[22]), 4'h0};
        if (nan_a | nan_b) begin
          r_fcc = 2'h3;
        end else if ((opa[30:0] == 31'h0) && (opb[30:0] == 31'h0)) begin
          r_fcc = 2'h0;
        end else if (ka < kb) begin
          r_fcc = 2'h1;
        end else if (ka > kb) begin
          r_fcc = 2'h2;
        end else begin
          r_fcc = 2'h0;
        end
      end
      // Conversions, square root, multiply and divide have no arithmetic core here
      default: begin
        r_done = 1'b0;
      end
    endcase
  end

  // Left-align the result so the even word leaves first
  reg [127:0] next_res;
  always @* begin
    case (nd)
      3'd1: next_res = {r_val[31:0], 96'h0};
      3'd2: next_res = {r_val[63:0], 64'h0};
      default: next_res = r_val;
    endcase
  end

  wire [1:0] ev_set = {(state == ST_CHECK) & ((mis1 | mis2 | misd) | ~shape[6]) |
                       (state == ST_EXEC) & ~r_done, state == ST_DONE};
  wire [1:0] next_irq_status = (irq_status & ~(clr_wr ? avs_writedata[1:0] : 2'h0)) | ev_set;

  // Operate sequencer
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      cexc <= 5'h00;
      fcc <= 2'h0;
      ftt <= `FTT_NONE;
      fcnt <= 4'd0;
      wcnt <= 3'd0;
      opa <= 128'h0;
      opb <= 128'h0;
      res <= 128'h0;
      trap_request <= 1'b0;
      float_exception_flag <= 1'b0;
      irq_status <= 2'h0;
      irq <= 1'b0;
    end else begin
      trap_request <= 1'b0;
      irq_status <= next_irq_status; // Set wins over clear
      irq <= |(next_irq_status & irq_enable);
      case (state)
        ST_IDLE: begin
          if (launch) begin
            float_exception_flag <= 1'b0;
            ftt <= `FTT_NONE;
            cexc <= 5'h00;
            opa <= 128'h0;
            opb <= 128'h0;
            fcnt <= 4'd0;
            state <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          if (mis1 | mis2 | misd) begin
            trap_request <= 1'b1;
            float_exception_flag <= 1'b1;
            ftt <= `FTT_INVALID_REG;
            state <= ST_DONE;
          end else if (!shape[6]) begin
            // Unknown opcode is reported as unfinished
            trap_request <= 1'b1;
            float_exception_flag <= 1'b1;
            ftt <= `FTT_UNFINISHED;
            state <= ST_DONE;
          end else if (nsrc == 4'd0) begin
            state <= ST_EXEC;
          end else begin
            state <= ST_ISSUE;
          end
        end
        ST_ISSUE: begin
          state <= ST_CAPT;
        end
        ST_CAPT: begin
          if (fcnt < {1'b0, n1}) begin
            opa <= {opa[95:0], mem_q};
          end else begin
            opb <= {opb[95:0], mem_q};
          end
          fcnt <= fcnt + 4'd1;
          state <= (fcnt + 4'd1 == nsrc) ? ST_EXEC : ST_ISSUE;
        end
        ST_EXEC: begin
          cexc <= r_exc;
          if (r_fcc_valid) begin
            fcc <= r_fcc;
          end
          if (!r_done) begin
            trap_request <= 1'b1;
            float_exception_flag <= 1'b1;
            ftt <= `FTT_UNFINISHED;
            state <= ST_DONE;
          end else begin
            res <= next_res;
            wcnt <= 3'd0;
            state <= (nd == 3'd0) ? ST_DONE : ST_WRITE;
          end
        end
        ST_WRITE: begin
          res <= {res[95:0], 32'h0};
          wcnt <= wcnt + 3'd1;
          if (wcnt + 3'd1 == nd) begin
            state <= ST_DONE;
          end
        end
        ST_DONE: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Avalon-MM slave: one answer per request, register-file reads one cycle later
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
      instr <= `RST_INSTR;
      irq_enable <= `RST_IRQ_ENABLE;
      mem_pend <= 1'b0;
    end else begin
      if (!avs_waitrequest) begin
        avs_waitrequest <= 1'b1;
      end else if (mem_pend) begin
        avs_readdata <= mem_q;
        avs_waitrequest <= 1'b0;
        mem_pend <= 1'b0;
      end else if (bus_fp_ok) begin
        if (avs_read) begin
          mem_pend <= 1'b1;
        end else begin
          avs_waitrequest <= 1'b0;
        end
      end else if (ctl_ok) begin
        avs_waitrequest <= 1'b0;
        avs_readdata <= 32'h0;
        if (avs_write) begin
          if (word_addr == `OFS_INSTR) begin
            instr <= instr_merged[23:0];
          end else if (word_addr == `OFS_IRQ_ENABLE) begin
            irq_enable <= avs_byteenable[0] ? avs_writedata[1:0] : irq_enable;
          end
        end else begin
          case (word_addr)
            `OFS_INSTR: avs_readdata <= {8'h00, instr};
            `OFS_STATUS: avs_readdata <= {state != ST_IDLE, 14'h0, ftt, 1'b0, float_exception_flag,
                                          fcc, 5'h00, cexc};
            `OFS_IRQ_STATUS: avs_readdata <= {30'h0, irq_status};
            `OFS_IRQ_ENABLE: avs_readdata <= {30'h0, irq_enable};
            default: avs_readdata <= 32'h0;
          endcase
        end
      end
    end
  end
endmodule // fp_operate_dispatch
`default_nettype wire

// File: design/fp_operate_map.vh
// Register map, field layout, reset values, trap-type, precision and opcode constants of the floating-point operate unit
`ifndef FP_OPERATE_MAP_VH
`define FP_OPERATE_MAP_VH

// Byte offsets on the register bus
`define OFS_INSTR      9'h000
`define OFS_STATUS     9'h004
`define OFS_IRQ_STATUS 9'h008
`define OFS_IRQ_CLEAR  9'h00c
`define OFS_IRQ_ENABLE 9'h010
`define FPREG_WIN_BIT  8

// Instruction register fields
`define INS_OPF_LSB 0
`define INS_RS2_LSB 9
`define INS_RS1_LSB 14
`define INS_RD_LSB  19

// Status register fields
`define ST_CEXC_LSB 0
`define ST_FCC_LSB  10
`define ST_FLAG_BIT 12
`define ST_FTT_LSB  14
`define ST_BUSY_BIT 31

// Interrupt status bits
`define IRQ_DONE_BIT 0
`define IRQ_TRAP_BIT 1

// Reset values
`define RST_INSTR      24'h000000
`define RST_IRQ_ENABLE 2'h0

// Trap-type codes
`define FTT_NONE        3'h0
`define FTT_UNFINISHED  3'h2
`define FTT_INVALID_REG 3'h6

// Precision codes
`define P_NONE 2'h0
`define P_S    2'h1
`define P_D    2'h2
`define P_Q    2'h3

// Operate opcodes
`define OP_INT_TO_SINGLE  9'h001
`define OP_INT_TO_DOUBLE  9'h002
`define OP_INT_TO_QUAD    9'h003
`define OP_SINGLE_TO_INT  9'h004
`define OP_DOUBLE_TO_INT  9'h005
`define OP_QUAD_TO_INT    9'h006
`define OP_SINGLE_TO_DBL  9'h007
`define OP_SINGLE_TO_QUAD 9'h008
`define OP_DOUBLE_TO_SGL  9'h009
`define OP_DOUBLE_TO_QUAD 9'h00a
`define OP_QUAD_TO_SGL    9'h00b
`define OP_QUAD_TO_DBL    9'h00c
`define OP_MOVE_SINGLE    9'h010
`define OP_NEGATE_SINGLE  9'h011
`define OP_ABS_SINGLE     9'h012
`define OP_SQRT_SINGLE    9'h020
`define OP_SQRT_DOUBLE    9'h021
`define OP_SQRT_QUAD      9'h022
`define OP_MUL_SINGLE     9'h030
`define OP_DIV_SINGLE     9'h031
`define OP_MUL_DOUBLE     9'h032
`define OP_SMUL_TO_DOUBLE 9'h033
`define OP_DIV_DOUBLE     9'h034
`define OP_MUL_QUAD       9'h035
`define OP_DMUL_TO_QUAD   9'h036
`define OP_DIV_QUAD       9'h037
`define OP_CMP_SINGLE     9'h040

`endif

// File: design/fp_reg_file.v
// Floating-point register file with byte-lane writes and a registered read port
`timescale 1ns/1ps
`default_nettype none
module fp_reg_file #(
  parameter WIDTH = 32,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  // Clock
  input wire ref_clk,
  // Write port
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [WIDTH-1:0] wdata,
  input wire [WIDTH/8-1:0] wbe,
  // Read port
  input wire [AW-1:0] raddr,
  output reg [WIDTH-1:0] rdata
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  integer i;

  always @(posedge ref_clk) begin
    if (we) begin
      for (i = 0; i < WIDTH / 8; i = i + 1) begin
        if (wbe[i]) begin
          mem[waddr][i*8 +: 8] <= wdata[i*8 +: 8];
        end
      end
    end
    rdata <= mem[raddr];
  end
endmodule // fp_reg_file
`default_nettype wire

// File: design/reg_spec_align.v
// Aligned register base and misalignment check for one register specifier
`timescale 1ns/1ps
`default_nettype none
`include "fp_operate_map.vh"
module reg_spec_align (
  // Specifier and operand precision
  input wire [4:0] spec,
  input wire [1:0] prec,
  // Aligned base register and fault
  output wire [4:0] base,
  output wire misaligned
);
  assign misaligned = ((prec == `P_D) & spec[0]) |
                      ((prec == `P_Q) & (|spec[1:0]));
  assign base = (prec == `P_Q) ? {spec[4:2], 2'b00} :
                (prec == `P_D) ? {spec[4:1], 1'b0} : spec;
endmodule // reg_spec_align
`default_nettype wire

// File: bench/issue_master.sv
// Integer-unit side model: issues operates and register accesses over Avalon-MM
`timescale 1ns/1ps
`default_nettype none
module issue_master (
  // Clock
  input wire logic ref_clk,
  // Avalon-MM master
  output logic [8:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  initial begin
    avs_address = 9'h000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
  end
  // Request stands until waitrequest is seen low
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    // Stale data would hide a missed capture
    avs_writedata <= ~d;
  endtask
  task automatic rd(input logic [8:0] a, output logic [31:0] q);
    @(posedge ref_clk);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
  endtask
endmodule // issue_master
`default_nettype wire

// File: bench/fp_operate_dispatch_sva.sv
// Bus timing and trap checks on the operate unit's ports
`timescale 1ns/1ps
`default_nettype none
`include "fp_operate_map.vh"
module fp_operate_dispatch_sva (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Avalon-MM slave
  input wire logic [8:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Events
  input wire logic irq,
  input wire logic trap_request,
  input wire logic float_exception_flag
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  wire logic ctrl = (avs_address[8] == 1'b0) && (avs_address[7:2] != 6'h00);
  a_wait_one_cycle:
    assert property (!avs_waitrequest |=> avs_waitrequest) else $error("waitrequest low too long");
  a_answer_has_cause:
    assert property (!avs_waitrequest |-> avs_read || avs_write) else $error("answer without request");
  a_ctrl_write_answer:
    assert property (avs_write && avs_waitrequest && ctrl |=> !avs_waitrequest) else $error("control write late");
  a_ctrl_read_answer:
    assert property ($rose(avs_read) && ctrl |=> !avs_waitrequest) else $error("control read late");
  a_fpreg_read_wait:
    assert property ($rose(avs_read) && avs_address[8] |=> avs_waitrequest) else $error("register read too early");
  a_answer_bounded:
    assert property ($rose(avs_read || avs_write) |-> ##[1:60] !avs_waitrequest) else $error("request not answered");
  a_trap_sets_flag:
    assert property (trap_request |-> float_exception_flag) else $error("trap without exception flag");
  a_trap_one_pulse:
    assert property (trap_request |=> !trap_request) else $error("trap request longer than a cycle");
  a_launch_clears_flag:
    assert property (!avs_waitrequest && avs_write && avs_address == `OFS_INSTR |-> !float_exception_flag)
      else $error("flag kept over launch");
  a_mask_drops_irq:
    assert property (!avs_waitrequest && avs_write && avs_address == `OFS_IRQ_ENABLE && avs_writedata[1:0] == 2'h0
      |=> !irq) else $error("irq stays after masking");
  c_trap: cover property (trap_request);
  c_irq: cover property ($rose(irq));
  c_fpreg_read: cover property ($rose(avs_read) && avs_address[8]);
endmodule // fp_operate_dispatch_sva
bind fp_operate_dispatch fp_operate_dispatch_sva u_sva (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .irq(irq), .trap_request(trap_request), .float_exception_flag(float_exception_flag));
`default_nettype wire

// File: bench/fp_operate_dispatch_tb_top.sv
// Self-checking bench for the floating-point operate unit
`timescale 1ns/1ps
`default_nettype none
`include "fp_operate_map.vh"
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin miscompares++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module fp_operate_dispatch_tb_top;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [8:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest, irq, trap_request, float_exception_flag;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0] avs_byteenable;
  int miscompares = 0;
  int n_compared = 0;
  int n_traps = 0;
  int exp_traps = 0;
  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (trap_request === 1'b1) n_traps++;
  fp_operate_dispatch DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .irq(irq), .trap_request(trap_request), .float_exception_flag(float_exception_flag));
  issue_master u_m (.ref_clk(ref_clk), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  task automatic run(input logic [8:0] op, input logic [4:0] s1, s2, d);
    u_m.wr(`OFS_INSTR, {8'h00, d, s1, s2, op});
    for (int i = 0; i < 100; i++) begin
      u_m.rd(`OFS_STATUS, q);
      if (q[`ST_BUSY_BIT] === 1'b0) break;
    end
    @(posedge ref_clk);
  endtask
  task automatic st_chk(input logic [2:0] ftt, input logic flag);
    `CHK(q[`ST_FTT_LSB +: 3], ftt)
    `CHK(q[`ST_FLAG_BIT], flag)
    `CHK(float_exception_flag, flag)
    `CHK(n_traps, exp_traps)
  endtask
  task automatic freg(input logic [4:0] r, input logic [31:0] e);
    u_m.rd(9'h100 + {r, 2'b00}, q);
    `CHK(q, e)
  endtask
  task automatic t_reset_regs();
    logic [8:0] a[5] = '{`OFS_INSTR, `OFS_STATUS, `OFS_IRQ_STATUS, `OFS_IRQ_ENABLE, 9'h020};
    foreach (a[i]) begin
      u_m.rd(a[i], q);
      `CHK(q, 32'h0)
    end
    // Read-only status must shrug off writes
    u_m.wr(`OFS_STATUS, 32'hffffffff);
    u_m.rd(`OFS_STATUS, q);
    `CHK(q, 32'h0)
    for (int i = 0; i < 16; i++) u_m.wr(9'h100 + 4 * i, 32'h5a5a0000 | i);
    u_m.wr(9'h104, 32'hc0a00001);
    u_m.wr(9'h10c, 32'h3f800000);
    u_m.wr(9'h114, 32'h3f800000);
    u_m.wr(9'h118, 32'h40000000);
    u_m.wr(9'h11c, 32'h7fc00000);
    u_m.wr(9'h124, 32'h7fa00000);
    freg(5'd6, 32'h40000000);
  endtask
  task automatic t_moves();
    logic [8:0] op[3] = '{`OP_MOVE_SINGLE, `OP_NEGATE_SINGLE, `OP_ABS_SINGLE};
    logic [31:0] e[6] = '{32'hc0a00001, 32'h40a00001, 32'h40a00001, 32'h3f800000, 32'hbf800000, 32'h3f800000};
    for (int i = 0; i < 6; i++) begin
      run(op[i % 3], 5'd0, (i < 3) ? 5'd1 : 5'd3, 5'd2);
      `CHK(q[`ST_CEXC_LSB +: 5], 5'h00)
      st_chk(`FTT_NONE, 1'b0);
      freg(5'd2, e[i]);
    end
  endtask
  task automatic t_misaligned();
    // Opcode, rs1, rs2, rd: one odd or unaligned specifier each
    logic [23:0] t[5] = '{{`OP_SQRT_DOUBLE, 5'd0, 5'd3, 5'd8}, {`OP_DIV_DOUBLE, 5'd1, 5'd2, 5'd8},
      {`OP_QUAD_TO_INT, 5'd0, 5'd2, 5'd8}, {`OP_DMUL_TO_QUAD, 5'd2, 5'd4, 5'd10}, {`OP_SINGLE_TO_DBL, 5'd0, 5'd1, 5'd11}};
    foreach (t[i]) begin
      run(t[i][23:15], t[i][14:10], t[i][9:5], t[i][4:0]);
      exp_traps++;
      st_chk(`FTT_INVALID_REG, 1'b1);
      freg(t[i][4:0], 32'h5a5a0000 | t[i][4:0]);
    end
  endtask
  task automatic t_unfinished();
    logic [8:0] op[22] = '{9'h001, 9'h002, 9'h003, 9'h004, 9'h005, 9'h006, 9'h007, 9'h008, 9'h009, 9'h00a,
      9'h00b, 9'h00c, 9'h020, 9'h021, 9'h022, 9'h030, 9'h031, 9'h032, 9'h033, 9'h034, 9'h035, 9'h036};
    foreach (op[i]) begin
      // Aligned quads everywhere, so only the missing arithmetic can trap
      run(op[i], 5'd4, 5'd8, 5'd12);
      exp_traps++;
      st_chk(`FTT_UNFINISHED, 1'b1);
      freg(5'd12, 32'h5a5a000c);
    end
    run(`OP_DIV_QUAD, 5'd4, 5'd8, 5'd12);
    exp_traps++;
    st_chk(`FTT_UNFINISHED, 1'b1);
    // Undecoded opcode ends as unfinished too
    run(9'h1ff, 5'd0, 5'd0, 5'd0);
    exp_traps++;
    st_chk(`FTT_UNFINISHED, 1'b1);
  endtask
  task automatic t_compare();
    logic [11:0] t[5] = '{{5'd5, 5'd3, 2'd0}, {5'd5, 5'd6, 2'd1}, {5'd6, 5'd5, 2'd2}, {5'd7, 5'd5, 2'd3},
      {5'd9, 5'd5, 2'd3}};
    foreach (t[i]) begin
      run(`OP_CMP_SINGLE, t[i][11:7], t[i][6:2], 5'd0);
      `CHK(q[`ST_FCC_LSB +: 2], t[i][1:0])
      `CHK(q[`ST_CEXC_LSB + 4], (i == 4))
      st_chk(`FTT_NONE, 1'b0);
    end
  endtask
  task automatic t_irq();
    u_m.wr(`OFS_IRQ_CLEAR, 32'h3);
    u_m.wr(`OFS_IRQ_ENABLE, 32'h1);
    run(`OP_MOVE_SINGLE, 5'd0, 5'd1, 5'd2);
    `CHK(irq, 1'b1)
    u_m.rd(`OFS_IRQ_ENABLE, q);
    `CHK(q[1:0], 2'h1)
    u_m.wr(`OFS_IRQ_CLEAR, 32'h1);
    @(posedge ref_clk);
    `CHK(irq, 1'b0)
    u_m.wr(`OFS_IRQ_ENABLE, 32'h2);
    run(`OP_MOVE_SINGLE, 5'd0, 5'd1, 5'd2);
    `CHK(irq, 1'b0)
    run(`OP_SQRT_QUAD, 5'd0, 5'd6, 5'd8);
    exp_traps++;
    `CHK(irq, 1'b1)
    u_m.rd(`OFS_IRQ_STATUS, q);
    `CHK(q[1:0], 2'h3)
    u_m.wr(`OFS_IRQ_ENABLE, 32'h0);
    @(posedge ref_clk);
    `CHK(irq, 1'b0)
    u_m.wr(`OFS_IRQ_CLEAR, 32'h3);
    u_m.rd(`OFS_IRQ_STATUS, q);
    `CHK(q[1:0], 2'h0)
  endtask
  task automatic summarize();
    if (miscompares == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_reset_regs();
    t_moves();
    t_misaligned();
    t_unfinished();
    t_compare();
    t_irq();
    summarize();
  end
  // About 40 operates of under 100 cycles each
  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    summarize();
  end
endmodule // fp_operate_dispatch_tb_top
`default_nettype wire
